// ==== s2_check.sv ====
/*
 * Second-stage configuration checks: effective output size, address size,
 * access flag and protected-walk faults, illegal configuration flag.
 * Assumes the walker presents one result at a time with walk_valid_i,
 * and that capability inputs are static.
 */
`timescale 1ns/10ps
`include "s2_check_params.svh"

// Operation
// - 32-bit format ignores size field; effective size is 40 bits.
// - 64-bit format: effective size is min of field and cap.
// - Cap limited to 52 bits later revision, 48 bits earlier.
// - Field above cap, reserved codes too, behaves as the cap.
// - Any output bit from 51 down to effective size raises fault.
// - Above 48 bits only with size 52 and 64KB granule.
// - Small granules zero bits 51:48; no fault at 48 or more.
// - Format select: 0 is 32-bit table, 1 is 64-bit table.
// - Unsupported table format with stage 2 enabled is illegal.
// - Endianness bit: 0 little-endian, 1 big-endian descriptor reads.
// - Unimplemented endianness with stage 2 enabled is illegal.
// - No hardware update, disable clear: flag 0 gives access fault.
// - Disable bit set: never access fault; flag treated as 1.
// - Hardware access-flag update enabled ignores disable bit.
// - Protected walk to Device page gives stage 2 permission fault.
// - Protected walk clear: walks to Device pages allowed.
// - No stage 2 support: all these fields read as zero.
module s2_check
  import s2_check_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic stage2_supported_i,
  input wire logic later_revision_i,
  input wire out_size_t output_addr_size_cap_i,
  input wire logic [1:0] table_format_support_i,
  input wire logic [1:0] endian_support_i,
  input wire logic [1:0] hw_table_update_i,
  input wire logic stage1_enable_i,
  input wire logic stage2_enable_i,
  input wire logic stage2_table_format_sel_i,
  input wire logic stage2_table_endianness_i,
  input wire out_size_t stage2_output_size_field_i,
  input wire logic stage2_access_flag_fault_disable_i,
  input wire logic protected_walk_enable_i,
  input wire logic stage2_hw_access_flag_update_i,
  input wire logic [1:0] stage2_granule_i,
  input wire logic fault_record_enable_i,
  input wire logic fault_stall_enable_i,
  input wire logic walk_valid_i,
  input wire access_kind_e walk_kind_i,
  input wire logic [51:0] walk_out_addr_i,
  input wire logic descriptor_access_flag_i,
  input wire logic walk_page_device_i,
  input wire logic [63:0] desc_raw_i,
  output logic [2:0] effective_output_size_o,
  output logic config_illegal_o,
  output logic desc_big_endian_o,
  output logic [63:0] desc_o,
  output logic [51:0] out_addr_o,
  output logic result_valid_o,
  output logic fault_valid_o,
  output fault_type_e fault_type_o,
  output logic fault_record_o,
  output logic fault_stall_o,
  output logic walk_terminate_o
);

  // Fields read as zero without stage 2 support
  logic fmt_sel;
  logic endi;
  logic affd;
  logic ptw;
  logic hw_af;
  logic rec_en;
  logic stall_en;
  out_size_t size_field;
  out_size_t cap;
  logic [2:0] eff_code;
  logic [5:0] eff_bits;

  always_comb
  begin
    fmt_sel = stage2_supported_i & stage2_table_format_sel_i;
    endi = stage2_supported_i & stage2_table_endianness_i;
    affd = stage2_supported_i & stage2_access_flag_fault_disable_i;
    ptw = stage2_supported_i & protected_walk_enable_i;
    hw_af = stage2_supported_i & stage2_hw_access_flag_update_i;
    rec_en = stage2_supported_i & fault_record_enable_i;
    stall_en = stage2_supported_i & fault_stall_enable_i;
    size_field = stage2_supported_i ? stage2_output_size_field_i : 3'h0;
  end

  always_comb
  begin
    if (later_revision_i)
    begin
      cap = (output_addr_size_cap_i > `S2C_CAP_MAX_LATER) ?
        `S2C_CAP_MAX_LATER : output_addr_size_cap_i;
    end
    else
    begin
      cap = (output_addr_size_cap_i > `S2C_CAP_MAX_EARLY) ?
        `S2C_CAP_MAX_EARLY : output_addr_size_cap_i;
    end
  end

  s2_size_resolve u_size (
    .fmt_sel_i(fmt_sel),
    .field_i(size_field),
    .cap_i(cap),
    .eff_code_o(eff_code)
  );

  assign eff_bits = size_bits(eff_code);

  // Configuration legality
  logic illegal_c;
  logic endian_ok;
  always_comb
  begin
    unique case (endian_support_i)
      `S2C_ENDS_MIXED: endian_ok = 1'b1;
      `S2C_ENDS_LITTLE: endian_ok = (endi == `S2C_END_LITTLE);
      `S2C_ENDS_BIG: endian_ok = (endi == `S2C_END_BIG);
      default: endian_ok = 1'b0;
    endcase
    illegal_c = 1'b0;
    if (stage2_supported_i && stage2_enable_i)
    begin
      // bit 0 is 32-bit, 1 is 64-bit
      if (fmt_sel == `S2C_FMT_32 && !table_format_support_i[0])
      begin
        illegal_c = 1'b1;
      end
      if (fmt_sel == `S2C_FMT_64 && !table_format_support_i[1])
      begin
        illegal_c = 1'b1;
      end
      if (!endian_ok)
      begin
        illegal_c = 1'b1;
      end
    end
  end

  // Walk result evaluation
  logic [51:0] addr_c;
  logic as_fault;
  logic af_fault;
  logic perm_fault;
  logic hw_af_active;
  logic [51:0] high_mask;
  logic [63:0] desc_c;
  logic [63:0] desc_swap;
  always_comb
  begin
    addr_c = walk_out_addr_i;
    // wide output only with 64KB granule, 64-bit format and later revision
    if (stage2_granule_i != `S2C_TG_64K || fmt_sel == `S2C_FMT_32 ||
        !later_revision_i)
    begin
      addr_c[51:48] = 4'h0;
    end
    // bits 51 down to effective size
    high_mask = ~((52'h1 << eff_bits) - 52'h1);
    as_fault = |(addr_c & high_mask);
    hw_af_active = hw_af && (hw_table_update_i != 2'h0) &&
      (fmt_sel == `S2C_FMT_64);
    af_fault = !hw_af_active && !affd && !descriptor_access_flag_i;
    perm_fault = ptw && stage1_enable_i && walk_page_device_i &&
      (walk_kind_i == ACC_S1_WALK || walk_kind_i == ACC_CD_FETCH);
    // descriptor byte order
    // Swap formed on its own; a stream cannot sit in a select
    desc_swap = {<<8{desc_raw_i}};
    if (endi == `S2C_END_BIG)
    begin
      desc_c = desc_swap;
    end
    else
    begin
      desc_c = desc_raw_i;
    end
  end

  // Registered results
  logic [2:0] eff_q;
  logic [2:0] eff_d;
  logic illegal_q;
  logic illegal_d;
  logic valid_q;
  logic valid_d;
  logic fvalid_q;
  logic fvalid_d;
  fault_type_e ftype_q;
  fault_type_e ftype_d;
  logic rec_q;
  logic rec_d;
  logic stall_q;
  logic stall_d;
  logic term_q;
  logic term_d;
  logic [51:0] addr_q;
  logic [51:0] addr_d;
  logic [63:0] desc_q;
  logic [63:0] desc_d;
  logic endi_q;
  logic endi_d;

  always_comb
  begin
    eff_d = eff_code;
    illegal_d = illegal_c;
    endi_d = endi;
    valid_d = walk_valid_i;
    fvalid_d = 1'b0;
    ftype_d = FAULT_NONE;
    term_d = 1'b0;
    addr_d = addr_q;
    desc_d = desc_q;
    if (walk_valid_i && stage2_enable_i && stage2_supported_i)
    begin
      addr_d = addr_c;
      desc_d = desc_c;
      // Permission first: the walk never completes
      if (perm_fault)
      begin
        fvalid_d = 1'b1;
        ftype_d = FAULT_PERMISSION;
        term_d = 1'b1;
      end
      else if (as_fault)
      begin
        fvalid_d = 1'b1;
        ftype_d = FAULT_ADDR_SIZE;
      end
      else if (af_fault)
      begin
        fvalid_d = 1'b1;
        ftype_d = FAULT_ACCESS_FLAG;
      end
    end
    rec_d = fvalid_d & rec_en;
    stall_d = fvalid_d & stall_en;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      eff_q <= 3'h0;
      illegal_q <= 1'b0;
      endi_q <= 1'b0;
      valid_q <= 1'b0;
      fvalid_q <= 1'b0;
      ftype_q <= FAULT_NONE;
      rec_q <= 1'b0;
      stall_q <= 1'b0;
      term_q <= 1'b0;
      addr_q <= 52'h0;
      desc_q <= 64'h0;
    end
    else if (clk_en_i)
    begin
      eff_q <= eff_d;
      illegal_q <= illegal_d;
      endi_q <= endi_d;
      valid_q <= valid_d;
      fvalid_q <= fvalid_d;
      ftype_q <= ftype_d;
      rec_q <= rec_d;
      stall_q <= stall_d;
      term_q <= term_d;
      addr_q <= addr_d;
      desc_q <= desc_d;
    end
  end

  assign effective_output_size_o = eff_q;
  assign config_illegal_o = illegal_q;
  assign desc_big_endian_o = endi_q;
  assign desc_o = desc_q;
  assign out_addr_o = addr_q;
  assign result_valid_o = valid_q;
  assign fault_valid_o = fvalid_q;
  assign fault_type_o = ftype_q;
  assign fault_record_o = rec_q;
  assign fault_stall_o = stall_q;
  assign walk_terminate_o = term_q;

endmodule : s2_check

// ==== s2_check_params.svh ====
/*
 * Constants for the second-stage configuration checks: field encodings,
 * output size codes and limits. Included by the package and the modules.
 */
`ifndef S2_CHECK_PARAMS_SVH
`define S2_CHECK_PARAMS_SVH

// Output size field encodings
`define S2C_PS_32 3'h0
`define S2C_PS_36 3'h1
`define S2C_PS_40 3'h2
`define S2C_PS_42 3'h3
`define S2C_PS_44 3'h4
`define S2C_PS_48 3'h5
`define S2C_PS_52 3'h6
`define S2C_PS_RSV 3'h7

// Cap limits per architecture revision
`define S2C_CAP_MAX_LATER 3'h6
`define S2C_CAP_MAX_EARLY 3'h5

// Table format select values
`define S2C_FMT_32 1'h0
`define S2C_FMT_64 1'h1

// Endianness values
`define S2C_END_LITTLE 1'h0
`define S2C_END_BIG 1'h1

// Endian support capability encodings
`define S2C_ENDS_MIXED 2'h0
`define S2C_ENDS_LITTLE 2'h2
`define S2C_ENDS_BIG 2'h3

// Granule encodings
`define S2C_TG_4K 2'h0
`define S2C_TG_64K 2'h1
`define S2C_TG_16K 2'h2

// Output address width
`define S2C_OA_W 52
// First bit forced to zero below 64KB granules
`define S2C_NARROW_BIT 48

`endif

// ==== s2_check_pkg.sv ====
/*
 * Types for the second-stage configuration checks.
 * Assumes s2_check_params.svh is on the include path.
 */
`include "s2_check_params.svh"

package s2_check_pkg;

  typedef logic [2:0] out_size_t;

  typedef enum logic [1:0] {
    FAULT_NONE = 2'h0,
    FAULT_ADDR_SIZE = 2'h1,
    FAULT_ACCESS_FLAG = 2'h2,
    FAULT_PERMISSION = 2'h3
  } fault_type_e;

  typedef enum logic [1:0] {
    ACC_CLIENT = 2'h0,
    ACC_S1_WALK = 2'h1,
    ACC_CD_FETCH = 2'h2
  } access_kind_e;

  // Size code to address width in bits
  function automatic logic [5:0] size_bits(input out_size_t code);
    logic [5:0] r;
    r = 6'h30;
    unique case (code)
      `S2C_PS_32: r = 6'h20;
      `S2C_PS_36: r = 6'h24;
      `S2C_PS_40: r = 6'h28;
      `S2C_PS_42: r = 6'h2A;
      `S2C_PS_44: r = 6'h2C;
      `S2C_PS_48: r = 6'h30;
      `S2C_PS_52: r = 6'h34;
      `S2C_PS_RSV: r = 6'h34;
    endcase
    return r;
  endfunction : size_bits

endpackage : s2_check_pkg

// ==== s2_size_resolve.sv ====
/*
 * Resolves the effective second-stage output size from the entry field,
 * the table format and the implemented cap. Purely combinational.
 * Assumes the cap input is already clamped to the revision limit.
 */
`timescale 1ns/10ps
`include "s2_check_params.svh"

module s2_size_resolve
  import s2_check_pkg::*;
(
  input wire logic fmt_sel_i,
  input wire out_size_t field_i,
  input wire out_size_t cap_i,
  output logic [2:0] eff_code_o
);

  always_comb
  begin
    if (fmt_sel_i == `S2C_FMT_32)
    begin
      eff_code_o = `S2C_PS_40;
    end
    else if (field_i > cap_i)
    begin
      eff_code_o = cap_i;
    end
    else
    begin
      eff_code_o = field_i;
    end
  end

endmodule : s2_size_resolve

// ==== s2_check_properties.sv ====
/* Checker for s2_check: walk answer, fault pulses and config outputs.
   Bound to every s2_check; walk and config checks skip cycles with the clock enable low, a_typed and a_term do not. */
`timescale 1ns/10ps
module s2_check_properties
  import s2_check_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic stage2_supported_i,
  input wire logic stage2_table_format_sel_i,
  input wire logic stage2_table_endianness_i,
  input wire logic fault_record_enable_i,
  input wire logic fault_stall_enable_i,
  input wire logic walk_valid_i,
  input wire access_kind_e walk_kind_i,
  input wire logic [2:0] effective_output_size_o,
  input wire logic desc_big_endian_o,
  input wire logic result_valid_o,
  input wire logic fault_valid_o,
  input wire fault_type_e fault_type_o,
  input wire logic fault_record_o,
  input wire logic fault_stall_o,
  input wire logic walk_terminate_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_answer;
    walk_valid_i && clk_en_i |=> result_valid_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("walk result pulse missing");
  property p_typed;
    fault_valid_o |-> result_valid_o && fault_type_o != FAULT_NONE;
  endproperty
  a_typed: assert property (p_typed)
    else $error("fault without type or result");
  property p_record;
    walk_valid_i && clk_en_i |=>
      fault_record_o == (fault_valid_o && $past(fault_record_enable_i));
  endproperty
  a_record: assert property (p_record)
    else $error("record pulse wrong");
  property p_stall;
    walk_valid_i && clk_en_i |=>
      fault_stall_o == (fault_valid_o && $past(fault_stall_enable_i));
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall pulse wrong");
  property p_term;
    walk_terminate_o == (fault_valid_o && fault_type_o == FAULT_PERMISSION);
  endproperty
  a_term: assert property (p_term)
    else $error("terminate not tied to permission fault");
  property p_client;
    walk_valid_i && clk_en_i && walk_kind_i == ACC_CLIENT |=>
      fault_type_o != FAULT_PERMISSION;
  endproperty
  a_client: assert property (p_client)
    else $error("client access got permission fault");
  property p_fmt32;
    clk_en_i && stage2_supported_i && !stage2_table_format_sel_i |=>
      effective_output_size_o == 3'h2;
  endproperty
  a_fmt32: assert property (p_fmt32)
    else $error("32-bit format size not 40 bits");
  property p_absent;
    // Format forced to 32-bit, so the size is the fixed 40 bits
    clk_en_i && !stage2_supported_i |=>
      effective_output_size_o == 3'h2 && !desc_big_endian_o;
  endproperty
  a_absent: assert property (p_absent)
    else $error("fields not zero without stage 2");
  property p_endian;
    clk_en_i && stage2_supported_i |=>
      desc_big_endian_o == $past(stage2_table_endianness_i);
  endproperty
  a_endian: assert property (p_endian)
    else $error("endianness output wrong");

  c_perm: cover property (fault_valid_o && fault_type_o == FAULT_PERMISSION);
  c_size: cover property (fault_valid_o && fault_type_o == FAULT_ADDR_SIZE);
  c_flag: cover property (fault_valid_o && fault_type_o == FAULT_ACCESS_FLAG);
endmodule : s2_check_properties

bind s2_check s2_check_properties u_props (.*);

// ==== s2_walker_model.sv ====
/* Walker model: presents one walk result for one cycle.
   Assumes calls are made at a falling clock edge. */
`timescale 1ns/10ps
module s2_walker_model
  import s2_check_pkg::*;
(
  input wire logic clk_sys_i,
  output logic walk_valid_o,
  output access_kind_e walk_kind_o,
  output logic [51:0] walk_out_addr_o,
  output logic descriptor_access_flag_o,
  output logic walk_page_device_o,
  output logic [63:0] desc_raw_o
);
  initial
  begin
    walk_valid_o = 1'b0;
    walk_kind_o = ACC_CLIENT;
    walk_out_addr_o = 52'h0;
    descriptor_access_flag_o = 1'b0;
    walk_page_device_o = 1'b0;
    desc_raw_o = 64'h0;
  end

  task automatic send(input access_kind_e k, input logic [51:0] a,
    input logic af, input logic dev, input logic [63:0] raw);
    walk_valid_o = 1'b1;
    walk_kind_o = k;
    walk_out_addr_o = a;
    descriptor_access_flag_o = af;
    walk_page_device_o = dev;
    desc_raw_o = raw;
    @(negedge clk_sys_i);
    walk_valid_o = 1'b0;
    // Stale lines must not look like the last result
    walk_out_addr_o = ~a;
    desc_raw_o = ~raw;
    descriptor_access_flag_o = ~af;
    walk_page_device_o = ~dev;
  endtask : send
endmodule : s2_walker_model

// ==== tb_s2_check.sv ====
/* Testbench for s2_check: size, fault and config cases.
   Assumes the walker model drives the walk inputs. */
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_s2_check
  import s2_check_pkg::*;
  ;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1;
  logic stage2_supported_i = 1'b1, later_revision_i = 1'b1;
  out_size_t output_addr_size_cap_i = 3'h6, stage2_output_size_field_i = 3'h5;
  logic [1:0] table_format_support_i = 2'h3, endian_support_i = 2'h0;
  logic [1:0] hw_table_update_i = 2'h1, stage2_granule_i = 2'h0;
  logic stage1_enable_i = 1'b1, stage2_enable_i = 1'b1, dev = 1'b0;
  logic stage2_table_format_sel_i = 1'b1, stage2_table_endianness_i = 1'b0;
  logic stage2_access_flag_fault_disable_i = 1'b0;
  logic protected_walk_enable_i = 1'b0, stage2_hw_access_flag_update_i = 1'b0;
  logic fault_record_enable_i = 1'b1, fault_stall_enable_i = 1'b0;
  logic walk_valid_i, descriptor_access_flag_i, walk_page_device_i;
  access_kind_e walk_kind_i;
  logic [51:0] walk_out_addr_i, out_addr_o;
  logic [63:0] desc_raw_i, desc_o;
  logic [2:0] effective_output_size_o;
  logic config_illegal_o, desc_big_endian_o, result_valid_o, fault_valid_o;
  logic fault_record_o, fault_stall_o, walk_terminate_o;
  fault_type_e fault_type_o;
  int failures = 0, n_checks = 0, f;

  s2_check uut (.*);
  s2_walker_model u_walk (
    .clk_sys_i(clk_sys_i),
    .walk_valid_o(walk_valid_i),
    .walk_kind_o(walk_kind_i),
    .walk_out_addr_o(walk_out_addr_i),
    .descriptor_access_flag_o(descriptor_access_flag_i),
    .walk_page_device_o(walk_page_device_i),
    .desc_raw_o(desc_raw_i)
  );

  always #4 clk_sys_i = ~clk_sys_i;

  task automatic final_report;
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic go(input access_kind_e k, input logic [51:0] a,
    input logic af, input fault_type_e ft, input logic [51:0] ea);
    @(negedge clk_sys_i);
    u_walk.send(k, a, af, dev, 64'h0102030405060708);
    `CHK(result_valid_o, 1'b1)
    `CHK(fault_type_o, ft)
    `CHK(fault_valid_o, ft != FAULT_NONE)
    `CHK(walk_terminate_o, ft == FAULT_PERMISSION)
    `CHK(fault_record_o, ft != FAULT_NONE && fault_record_enable_i)
    `CHK(fault_stall_o, ft != FAULT_NONE && fault_stall_enable_i)
    `CHK(out_addr_o, ea)
    `CHK(desc_o, stage2_table_endianness_i ? 64'h0807060504030201 :
      64'h0102030405060708)
  endtask : go

  task automatic eff(input logic [2:0] e);
    @(negedge clk_sys_i);
    `CHK(effective_output_size_o, e)
  endtask : eff

  initial
  begin
    #20000;
    failures++;
    final_report();
  end

  initial
  begin
    repeat (12) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    for (f = 0; f < 8; f++)
    begin
      stage2_output_size_field_i = 3'(f);
      eff((f > 6) ? 3'h6 : 3'(f));
    end
    later_revision_i = 1'b0;
    eff(3'h5);
    stage2_table_format_sel_i = 1'b0;
    eff(3'h2);
    later_revision_i = 1'b1;
    stage2_table_format_sel_i = 1'b1;
    stage2_output_size_field_i = 3'h2;
    go(ACC_CLIENT, 52'h100_0000_0000, 1, FAULT_ADDR_SIZE,
      52'h100_0000_0000);
    go(ACC_CLIENT, 52'h0FF_FFFF_FFFF, 1, FAULT_NONE,
      52'h0FF_FFFF_FFFF);
    stage2_output_size_field_i = 3'h6;
    go(ACC_CLIENT, 52'h4_0000_0000_1000, 1, FAULT_NONE, 52'h1000);
    stage2_granule_i = 2'h1;
    go(ACC_CLIENT, 52'h4_0000_0000_1000, 1, FAULT_NONE,
      52'h4_0000_0000_1000);
    stage2_output_size_field_i = 3'h5;
    go(ACC_CLIENT, 52'h4_0000_0000_0000, 1, FAULT_ADDR_SIZE,
      52'h4_0000_0000_0000);
    // Earlier revision never passes bits above 48
    later_revision_i = 1'b0;
    go(ACC_CLIENT, 52'h4_0000_0000_2000, 1, FAULT_NONE, 52'h2000);
    later_revision_i = 1'b1;
    stage2_granule_i = 2'h0;
    fault_stall_enable_i = 1'b1;
    go(ACC_CLIENT, 52'h1000, 0, FAULT_ACCESS_FLAG, 52'h1000);
    stage2_access_flag_fault_disable_i = 1'b1;
    go(ACC_CLIENT, 52'h1000, 0, FAULT_NONE, 52'h1000);
    stage2_access_flag_fault_disable_i = 1'b0;
    stage2_hw_access_flag_update_i = 1'b1;
    go(ACC_CLIENT, 52'h1000, 0, FAULT_NONE, 52'h1000);
    protected_walk_enable_i = 1'b1;
    dev = 1'b1;
    go(ACC_S1_WALK, 52'h2000, 1, FAULT_PERMISSION, 52'h2000);
    go(ACC_CD_FETCH, 52'h2000, 1, FAULT_PERMISSION, 52'h2000);
    go(ACC_CLIENT, 52'h2000, 1, FAULT_NONE, 52'h2000);
    protected_walk_enable_i = 1'b0;
    stage2_table_endianness_i = 1'b1;
    go(ACC_S1_WALK, 52'h3000, 1, FAULT_NONE, 52'h3000);
    table_format_support_i = 2'h1;
    @(negedge clk_sys_i);
    `CHK(config_illegal_o, 1'b1)
    table_format_support_i = 2'h3;
    endian_support_i = 2'h2;
    @(negedge clk_sys_i);
    `CHK(config_illegal_o, 1'b1)
    endian_support_i = 2'h3;
    @(negedge clk_sys_i);
    `CHK(config_illegal_o, 1'b0)
    // Frozen by the clock enable: no answer, address held
    clk_en_i = 1'b0;
    u_walk.send(ACC_S1_WALK, 52'h6000, 1, dev, 64'h0);
    `CHK(result_valid_o, 1'b0)
    `CHK(out_addr_o, 52'h3000)
    clk_en_i = 1'b1;
    stage2_enable_i = 1'b0;
    go(ACC_CLIENT, 52'h5000, 0, FAULT_NONE, 52'h3000);
    stage2_supported_i = 1'b0;
    stage2_enable_i = 1'b1;
    eff(3'h2);
    `CHK(desc_big_endian_o, 1'b0)
    `CHK(config_illegal_o, 1'b0)
    go(ACC_CLIENT, 52'h7000, 0, FAULT_NONE, 52'h3000);
    final_report();
  end
endmodule : tb_s2_check
